/* File: verilog/srxe_top.sv */
// Receive framing and error flags of a bit-synchronous serial receiver
// Assumes modem clock and data are pins asynchronous to mclk; registers on a plain port
`timescale 1ns/1ps
module srxe_top (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic [srxe_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [srxe_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [srxe_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       modem_rx_clk,
  input  wire logic                       modem_rx_data,
  output logic                            irq
);
  import srxe_pkg::*;

  logic              rxc_s, rxd_s, rxc_q, bit_stb;
  logic              en_q, bytem_q;
  srxe_state_e       st_q;
  logic [7:0]        win_q, win_n, sh_q, sh_n, hold_q, xbyte, data_q;
  logic [2:0]        ones_q;
  logic [3:0]        cnt_q;
  logic              have_q, eom_pend_q;
  logic [15:0]       crc_q, crc_new;
  logic              is_flag, is_abort, is_del, take, full;
  logic              xfer_data, xfer_eom, xfer;
  logic              eom_q, ovr_q, crcf_q, abt_q, done_q, rd_seen_q, err_q, err_sum;
  logic              sel_buf, sel_ctl, sel_ist, sel_imk, rd_buf;
  logic [IRQ_W-1:0]  irq_st_q, irq_mk_q, irq_ev, irq_clr;
  logic [DATA_W-1:0] rd_mux;

  // ****************************************************
  // Pin synchronisation and bit strobe
  // ****************************************************
  srxe_sync #(.W(2)) u_sync (
    .clk    (mclk),
    .rstn   (rstn),
    .async_i({modem_rx_clk, modem_rx_data}),
    .sync_o ({rxc_s, rxd_s})
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxc_q <= 1'b0;
    end else begin
      rxc_q <= rxc_s;
    end
  end

  assign bit_stb = rxc_s & ~rxc_q;

  // ****************************************************
  // Register decode and control register
  // ****************************************************
  assign sel_buf = reg_addr == OFF_RXBUF;
  assign sel_ctl = reg_addr == OFF_CTL;
  assign sel_ist = reg_addr == OFF_IRQ_ST;
  assign sel_imk = reg_addr == OFF_IRQ_MK;
  assign rd_buf  = reg_rd & sel_buf;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_q    <= 1'b0;
      bytem_q <= 1'b0;
    end else if (reg_wr && sel_ctl) begin
      en_q    <= reg_wdata[CTL_EN];
      bytem_q <= reg_wdata[CTL_BYTE];
    end
  end

  // ****************************************************
  // Bit-level decode
  // ****************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d, input logic [15:0] poly);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ poly) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  assign win_n    = {rxd_s, win_q[7:1]};
  assign sh_n     = {rxd_s, sh_q[7:1]};
  assign is_flag  = bit_stb & ~bytem_q & (win_n == FLAG_CHAR);
  assign is_abort = bit_stb & ~bytem_q & rxd_s & (ones_q == ONES_ABORT) & (st_q != ST_HUNT);
  assign is_del   = bit_stb & ~bytem_q & ~rxd_s & (ones_q == ONES_DEL);
  assign take     = bit_stb & (st_q != ST_HUNT) & ~is_flag & ~is_abort & ~is_del;
  assign full     = take & (cnt_q == CHAR_LAST);
  assign xfer_data = bytem_q ? full
                   : (st_q == ST_FRAME) & (full | (is_flag & have_q));
  assign xfer_eom  = eom_pend_q & bit_stb & ~is_abort;
  assign xfer      = xfer_data | xfer_eom;
  assign xbyte     = bytem_q ? sh_n : hold_q;
  assign crc_new   = crc_step(crc_q, xbyte, bytem_q ? CRC_POLY_BYTE : CRC_POLY_BIT);

  // ****************************************************
  // Receiver framing state
  // ****************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= ST_HUNT;
      win_q      <= RST_BYTE;
      ones_q     <= '0;
      cnt_q      <= '0;
      sh_q       <= RST_BYTE;
      hold_q     <= RST_BYTE;
      have_q     <= 1'b0;
      eom_pend_q <= 1'b0;
      crc_q      <= CRC_INIT_BIT;
    end else if (!en_q || is_abort) begin
      st_q       <= ST_HUNT;
      win_q      <= RST_BYTE;
      ones_q     <= is_abort ? ONES_MAX : 3'h0;
      cnt_q      <= '0;
      sh_q       <= RST_BYTE;
      hold_q     <= RST_BYTE;
      have_q     <= 1'b0;
      eom_pend_q <= 1'b0;
      crc_q      <= CRC_INIT_BIT;
    end else if (bit_stb) begin
      win_q      <= win_n;
      ones_q     <= !rxd_s ? 3'h0 : (ones_q == ONES_MAX) ? ones_q : ones_q + 3'h1;
      eom_pend_q <= is_flag & (st_q == ST_FRAME);
      if (bytem_q) begin
        if (st_q == ST_HUNT) begin
          if (win_n == SYNC_CHAR) begin
            st_q  <= ST_FRAME;
            cnt_q <= '0;
            crc_q <= CRC_INIT_BYTE;
          end
        end else begin
          sh_q  <= sh_n;
          cnt_q <= full ? 4'h0 : cnt_q + 4'h1;
          if (full) begin
            crc_q <= crc_new;
          end
        end
      end else if (is_flag) begin
        st_q   <= ST_SYNC;
        cnt_q  <= '0;
        have_q <= 1'b0;
        if (xfer_data) begin
          crc_q <= crc_new;
        end
      end else if (take) begin
        sh_q  <= sh_n;
        cnt_q <= full ? 4'h0 : cnt_q + 4'h1;
        if (full) begin
          hold_q <= sh_n;
          have_q <= 1'b1;
          case (st_q)
            ST_SYNC: begin
              st_q  <= ST_FRAME;
              crc_q <= CRC_INIT_BIT;
            end
            ST_FRAME: begin
              crc_q <= crc_new;
            end
            default: begin
              st_q <= ST_HUNT;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************
  // Data byte, end-of-message and CRC flag
  // ****************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_q <= RST_BYTE;
      eom_q  <= 1'b0;
      crcf_q <= 1'b0;
    end else if (!en_q || is_abort) begin
      data_q <= RST_BYTE;
      eom_q  <= 1'b0;
      crcf_q <= 1'b0;
    end else if (xfer_data) begin
      data_q <= xbyte;
      eom_q  <= 1'b0;
      crcf_q <= bytem_q & (crc_new == CRC_INIT_BYTE);
    end else if (xfer_eom) begin
      eom_q  <= 1'b1;
      crcf_q <= crc_q != CRC_GOOD_BIT;
    end
  end

  // ****************************************************
  // Receive-done, abort and overrun flags
  // ****************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      abt_q  <= 1'b0;
    end else if (!en_q) begin
      done_q <= 1'b0;
      abt_q  <= 1'b0;
    end else begin
      done_q <= xfer | is_abort | (done_q & ~rd_buf);
      abt_q  <= is_abort | (abt_q & ~rd_buf);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovr_q     <= 1'b0;
      rd_seen_q <= 1'b0;
    end else if (!en_q) begin
      ovr_q     <= 1'b0;
      rd_seen_q <= 1'b0;
    end else if (xfer) begin
      ovr_q     <= (done_q & ~rd_buf) | (ovr_q & ~rd_seen_q & ~rd_buf);
      rd_seen_q <= 1'b0;
    end else if (rd_buf) begin
      rd_seen_q <= 1'b1;
    end
  end

  assign err_sum = ovr_q | (crcf_q & ~bytem_q) | abt_q;

  // ****************************************************
  // Interrupt status and mask
  // ****************************************************
  assign irq_ev  = {err_sum & ~err_q, xfer | is_abort};
  assign irq_clr = (reg_wr && sel_ist) ? reg_wdata[IRQ_W-1:0] : RST_IRQ;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      err_q    <= 1'b0;
      irq_st_q <= RST_IRQ;
      irq_mk_q <= RST_IRQ;
      irq      <= 1'b0;
    end else begin
      err_q    <= err_sum;
      irq_st_q <= irq_ev | (irq_st_q & ~irq_clr);
      irq      <= |(irq_st_q & irq_mk_q);
      if (reg_wr && sel_imk) begin
        irq_mk_q <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_comb begin
    rd_mux = RST_WORD;
    if (sel_buf) begin
      rd_mux[BIT_ERR]  = err_sum;
      rd_mux[BIT_OVR]  = ovr_q;
      rd_mux[BIT_CRC]  = crcf_q;
      rd_mux[BIT_ABT]  = abt_q;
      rd_mux[BIT_EOM]  = eom_q;
      rd_mux[7:0]      = data_q;
    end else if (sel_ctl) begin
      rd_mux[CTL_EN]   = en_q;
      rd_mux[CTL_BYTE] = bytem_q;
      rd_mux[CTL_DONE] = done_q;
    end else if (sel_ist) begin
      rd_mux[IRQ_W-1:0] = irq_st_q;
    end else if (sel_imk) begin
      rd_mux[IRQ_W-1:0] = irq_mk_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RST_WORD;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_err_read;
    rd_buf |=> reg_rdata[BIT_ERR] == ($past(ovr_q) | ($past(crcf_q) & ~$past(bytem_q)) | $past(abt_q));
  endproperty
  a_err_read: assert property (p_err_read) else $error("error summary read wrong");

  property p_byte_mask;
    rd_buf && bytem_q && crcf_q && !ovr_q && !abt_q |=> !reg_rdata[BIT_ERR];
  endproperty
  a_byte_mask: assert property (p_byte_mask) else $error("CRC flag leaked into summary");

  property p_err_fall;
    $fell(err_sum) |-> !ovr_q && !abt_q;
  endproperty
  a_err_fall: assert property (p_err_fall) else $error("summary dropped with error set");

  property p_ovr_set;
    xfer && done_q && !rd_buf && en_q |=> ovr_q;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");

  property p_ovr_hold;
    ovr_q && en_q && !xfer |=> ovr_q;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped early");

  property p_dis_clear;
    !en_q |=> !ovr_q && !crcf_q && !done_q && !abt_q && st_q == ST_HUNT;
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("disable did not clear flags");

  property p_crc_eom;
    xfer_eom && en_q && crc_q != CRC_GOOD_BIT |=> crcf_q && eom_q;
  endproperty
  a_crc_eom: assert property (p_crc_eom) else $error("bit mode CRC error missed");

  property p_crc_zero;
    xfer_data && en_q && bytem_q && crc_new == CRC_INIT_BYTE |=> crcf_q;
  endproperty
  a_crc_zero: assert property (p_crc_zero) else $error("byte mode zero CRC missed");

  property p_crc_hold;
    crcf_q && en_q && !xfer && !is_abort |=> crcf_q;
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("CRC flag dropped early");

  property p_abort_reset;
    is_abort && en_q |=> abt_q && done_q && err_sum && data_q == RST_BYTE && st_q == ST_HUNT;
  endproperty
  a_abort_reset: assert property (p_abort_reset) else $error("abort effects missing");

  property p_abort_once;
    is_abort |=> !is_abort [*8];
  endproperty
  a_abort_once: assert property (p_abort_once) else $error("repeated abort reported");

  property p_eom_flag;
    is_flag && st_q == ST_FRAME && en_q |=> eom_pend_q && !eom_q;
  endproperty
  a_eom_flag: assert property (p_eom_flag) else $error("end-of-message not armed");

  property p_eom_set;
    xfer_eom && en_q |=> eom_q && !eom_pend_q;
  endproperty
  a_eom_set: assert property (p_eom_set) else $error("end-of-message not raised");

  property p_rsvd;
    rd_buf |=> reg_rdata[13] == 1'b0 && reg_rdata[11] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  c_ovr:   cover property ($rose(ovr_q));
  c_abort: cover property ($rose(abt_q));
  c_eom:   cover property ($rose(eom_q) && crcf_q);
  c_bcrc:  cover property (bytem_q && $rose(crcf_q));

endmodule : srxe_top

/* File: verilog/srxe_pkg.sv */
// Constants, register map and field layout of the sync receiver error flags block
// Assumes one system clock; modem clock and data are asynchronous pins
// What this block does
// - Error summary ORs overrun, CRC, abort flags
// - Byte-count mode drops CRC flag from summary
// - Summary read-only, drops when contributors clear
// - Overrun when buffer unread by next transfer
// - Overrun holds; clears at transfer after read
// - Overrun read-only; cleared by reset, disable
// - Byte-count mode: flag when accumulator is zero
// - CRC flag holds until next buffer transfer or abort
// - CRC flag read-only; cleared by reset, disable
// - Abort sets flag, resets receiver and data
// - Back-to-back aborts report only the first
// - Abort also sets receive-done and error summary
// - Disable resets receiver and clears receive-done
// - Closing flag inside frame sets end-of-message

package srxe_pkg;

  // ****************************************************
  // Register port
  // ****************************************************
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned IRQ_W      = 2;
  localparam logic [7:0]  OFF_RXBUF  = 8'h00;
  localparam logic [7:0]  OFF_CTL    = 8'h04;
  localparam logic [7:0]  OFF_IRQ_ST = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MK = 8'h0C;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int unsigned BIT_ERR    = 15;
  localparam int unsigned BIT_OVR    = 14;
  localparam int unsigned BIT_CRC    = 12;
  localparam int unsigned BIT_ABT    = 10;
  localparam int unsigned BIT_EOM    = 9;
  localparam int unsigned CTL_EN     = 0;
  localparam int unsigned CTL_BYTE   = 1;
  localparam int unsigned CTL_DONE   = 7;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_ERR    = 1;

  // ****************************************************
  // Reset values, characters, counts
  // ****************************************************
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  FLAG_CHAR     = 8'h7E;
  localparam logic [7:0]  SYNC_CHAR     = 8'h96;
  localparam logic [15:0] CRC_POLY_BIT  = 16'h8408;
  localparam logic [15:0] CRC_INIT_BIT  = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD_BIT  = 16'hF0B8;
  localparam logic [15:0] CRC_POLY_BYTE = 16'hA001;
  localparam logic [15:0] CRC_INIT_BYTE = 16'h0000;
  localparam logic [2:0]  ONES_DEL      = 3'h5;
  localparam logic [2:0]  ONES_ABORT    = 3'h6;
  localparam logic [2:0]  ONES_MAX      = 3'h7;
  localparam logic [3:0]  CHAR_LAST     = 4'h7;

  typedef enum logic [1:0] {ST_HUNT, ST_SYNC, ST_FRAME} srxe_state_e;

endpackage : srxe_pkg

/* File: verilog/srxe_sync.sv */
// Two-flop synchroniser for asynchronous pin levels
// Assumes inputs are slow levels relative to clk
`timescale 1ns/1ps
module srxe_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ****************************************************
  // One synchroniser per bit
  // ****************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_q[i] <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_o[i] <= meta_q[i];
      end
    end
  end

endmodule : srxe_sync

/* File: test/srxe_modem.sv */
// Behavioural synchronous modem: receive clock and serial data
// Assumes the bench calls its tasks; clock stands still between calls
`timescale 1ns/1ps
module srxe_modem (
  output logic rx_clk,
  output logic rx_data
);
  int ones;

  initial begin
    rx_clk  = 1'b0;
    rx_data = 1'b0;
    ones    = 0;
  end

  // ****************************************
  // Bit and character senders
  // ****************************************
  // One bit in 64 ns; the line shows the inverse once hold time ends
  task automatic send_bit(input logic b);
    rx_data = b;
    #16 rx_clk = 1'b1;
    #32 rx_clk = 1'b0;
    #8 rx_data = ~b;
    #8;
  endtask : send_bit

  // LSB first, optional zero insertion after five ones
  task automatic send_char(input logic [7:0] c, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      send_bit(c[i]);
      ones = c[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        send_bit(1'b0);
        ones = 0;
      end
    end
  endtask : send_char

  task automatic send_flag();
    send_char(8'h7E, 1'b0);
    ones = 0;
  endtask : send_flag

  task automatic send_ones(input int n);
    for (int i = 0; i < n; i++) begin
      send_bit(1'b1);
    end
    ones = 0;
  endtask : send_ones
endmodule : srxe_modem

/* File: test/tb.sv */
// Self-checking bench of the sync receiver error flags block
// Assumes srxe_modem drives the link pins; registers on a plain port
`timescale 1ns/1ps
module tb;
  import srxe_pkg::*;
  logic              mclk;
  logic              rstn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              rx_clk;
  logic              rx_data;
  logic              irq;
  int                n_mismatch;
  int                total_checks;
  int                cycles = 0;

  srxe_top uut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_rx_clk(rx_clk),
    .modem_rx_data(rx_data), .irq(irq));
  srxe_modem modem (.rx_clk(rx_clk), .rx_data(rx_data));

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(name, exp, reg_rdata);
  endtask : rd_chk

  function automatic logic [15:0] fcs(input logic [7:0] b0, input logic [7:0] b1);
    logic [15:0] c;
    logic [15:0] d;
    c = CRC_INIT_BIT;
    d = {b1, b0};
    for (int i = 0; i < 16; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY_BIT : c >> 1;
    end
    return ~c;
  endfunction : fcs

  task automatic restart(input logic [15:0] ctl);
    wr(OFF_CTL, 16'h0000);
    rd_chk("flags off", OFF_RXBUF, 16'h0000);
    rd_chk("done off", OFF_CTL, 16'h0000);
    wr(OFF_CTL, ctl);
  endtask : restart

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk("buffer", OFF_RXBUF, RST_WORD);
    rd_chk("control", OFF_CTL, RST_WORD);
    rd_chk("irq status", OFF_IRQ_ST, RST_WORD);
    rd_chk("unmapped", 8'h10, RST_WORD);
    wr(OFF_RXBUF, 16'hFFFF);
    wr(8'h10, 16'hFFFF);
    rd_chk("buffer ro", OFF_RXBUF, RST_WORD);
    wr(OFF_CTL, 16'hFFFF);
    rd_chk("control rw", OFF_CTL, 16'h0003);
    wr(OFF_IRQ_MK, 16'hFFFF);
    rd_chk("mask rw", OFF_IRQ_MK, 16'h0003);
    wr(OFF_IRQ_MK, 16'h0000);
  endtask : t_reset

  task automatic t_frame(input logic bad);
    logic [7:0]  ch [4];
    logic [15:0] f;
    f  = fcs(8'hFF, 8'h5A) ^ {15'h0000, bad};
    ch = '{8'hFF, 8'h5A, f[7:0], f[15:8]};
    restart(16'h0001);
    modem.send_flag();
    for (int i = 0; i < 4; i++) begin
      modem.send_char(ch[i], 1'b1);
      if (i > 0) begin
        rd_chk("frame data", OFF_RXBUF, {8'h00, ch[i-1]});
      end
    end
    modem.send_flag();
    rd_chk("last data", OFF_RXBUF, {8'h00, ch[3]});
    modem.send_flag();
    rd_chk("end word", OFF_RXBUF, {bad, 2'b00, bad, 4'b0010, ch[3]});
  endtask : t_frame

  task automatic t_overrun();
    restart(16'h0001);
    wr(OFF_IRQ_ST, 16'h0003);
    wr(OFF_IRQ_MK, 16'h0002);
    modem.send_flag();
    modem.send_char(8'h11, 1'b1);
    modem.send_char(8'h22, 1'b1);
    check("irq quiet", 16'h0000, {15'h0000, irq});
    modem.send_char(8'h33, 1'b1);
    check("irq raised", 16'h0001, {15'h0000, irq});
    rd_chk("overrun", OFF_RXBUF, 16'hC022);
    rd_chk("overrun held", OFF_RXBUF, 16'hC022);
    modem.send_char(8'h44, 1'b1);
    rd_chk("overrun relieved", OFF_RXBUF, 16'h0033);
    check("irq sticky", 16'h0001, {15'h0000, irq});
    wr(OFF_IRQ_ST, 16'h0002);
    rd_chk("status cleared", OFF_IRQ_ST, 16'h0001);
    check("irq cleared", 16'h0000, {15'h0000, irq});
    wr(OFF_IRQ_MK, 16'h0000);
    modem.send_char(8'h55, 1'b1);
    modem.send_char(8'h66, 1'b1);
    rd_chk("overrun again", OFF_RXBUF, 16'hC055);
  endtask : t_overrun

  task automatic t_bytecount();
    restart(16'h0003);
    modem.send_char(SYNC_CHAR, 1'b0);
    modem.send_char(8'h00, 1'b0);
    rd_chk("zero crc", OFF_RXBUF, 16'h1000);
    modem.send_char(8'h01, 1'b0);
    rd_chk("crc dropped", OFF_RXBUF, 16'h0001);
    modem.send_char(8'h02, 1'b0);
    rd_chk("done held", OFF_CTL, 16'h0083);
  endtask : t_bytecount

  task automatic t_abort();
    restart(16'h0001);
    modem.send_ones(10);
    rd_chk("ones in hunt", OFF_RXBUF, 16'h0000);
    modem.send_flag();
    modem.send_char(8'h11, 1'b1);
    modem.send_char(8'h22, 1'b1);
    rd_chk("before abort", OFF_RXBUF, 16'h0011);
    modem.send_ones(7);
    rd_chk("abort done", OFF_CTL, 16'h0081);
    rd_chk("abort", OFF_RXBUF, 16'h8400);
    modem.send_ones(9);
    rd_chk("no second abort", OFF_RXBUF, 16'h0000);
    modem.send_flag();
    modem.send_char(8'h33, 1'b1);
    modem.send_char(8'h44, 1'b1);
    rd_chk("resync", OFF_RXBUF, 16'h0033);
  endtask : t_abort

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    mclk         = 1'b0;
    rstn         = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    n_mismatch   = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    $display("reset test done");
    t_frame(1'b0);
    $display("good frame test done");
    t_frame(1'b1);
    $display("bad frame test done");
    t_overrun();
    $display("overrun test done");
    t_bytecount();
    $display("byte count test done");
    t_abort();
    $display("abort test done");
    complete_run();
  end
endmodule : tb
